// ===== src/sfcd_pkg.sv
package sfcd_pkg;

  // ****************************************************
  // Command codes
  // ****************************************************
  localparam logic [7:0] CMD_VERSION_QUERY   = 8'h01;
  localparam logic [7:0] CMD_SERIAL_RATE_SET = 8'h02;
  localparam logic [7:0] CMD_STATUS_FETCH    = 8'h22;
  localparam logic [7:0] CMD_RESULT_DATA_RD  = 8'h27;
  localparam logic [7:0] CMD_HOST_BUF_WRITE  = 8'h2c;
  localparam logic [7:0] CMD_OFS_BUF_WRITE   = 8'h2e;
  localparam logic [7:0] CMD_FILE_NAME_SET   = 8'h2f;
  localparam logic [7:0] CMD_DISK_ATTACH     = 8'h30;
  localparam logic [7:0] CMD_DISK_INIT_READY = 8'h31;
  localparam logic [7:0] CMD_FILE_OPEN       = 8'h32;
  localparam logic [7:0] CMD_ENUM_NEXT       = 8'h33;
  localparam logic [7:0] CMD_FILE_CREATE     = 8'h34;
  localparam logic [7:0] CMD_FILE_DELETE     = 8'h35;
  localparam logic [7:0] CMD_FILE_CLOSE      = 8'h36;
  localparam logic [7:0] CMD_DIR_ENTRY_READ  = 8'h37;
  localparam logic [7:0] CMD_DIR_ENTRY_SAVE  = 8'h38;
  localparam logic [7:0] CMD_BYTE_SEEK       = 8'h39;
  localparam logic [7:0] CMD_BYTE_READ       = 8'h3a;
  localparam logic [7:0] CMD_BYTE_READ_NEXT  = 8'h3b;
  localparam logic [7:0] CMD_BYTE_WRITE      = 8'h3c;
  localparam logic [7:0] CMD_BYTE_WRITE_NEXT = 8'h3d;
  localparam logic [7:0] CMD_DISK_CAPACITY   = 8'h3e;
  localparam logic [7:0] CMD_DISK_SPACE      = 8'h3f;
  localparam logic [7:0] CMD_DIR_CREATE      = 8'h40;
  localparam logic [7:0] CMD_SECTOR_SEEK     = 8'h4a;
  localparam logic [7:0] CMD_SECTOR_READ     = 8'h4b;
  localparam logic [7:0] CMD_SECTOR_WRITE    = 8'h4c;
  localparam logic [7:0] CMD_BULK_ONLY       = 8'h50;
  localparam logic [7:0] CMD_PHYS_READ       = 8'h54;
  localparam logic [7:0] CMD_PHYS_READ_NEXT  = 8'h55;
  localparam logic [7:0] CMD_PHYS_WRITE      = 8'h56;
  localparam logic [7:0] CMD_PHYS_WRITE_NEXT = 8'h57;

  // ****************************************************
  // Status codes and constants
  // ****************************************************
  localparam logic [7:0] IMMEDIATE_OK_CODE   = 8'h51;
  localparam logic [7:0] IMMEDIATE_FAIL_CODE = 8'h5f;
  localparam logic [7:0] INT_SUCCESS_CODE    = 8'h14;
  localparam logic [7:0] RATE_FACTOR_SLOW    = 8'h02;
  localparam logic [7:0] RATE_FACTOR_FAST    = 8'h03;
  localparam logic [1:0] VERSION_TAG         = 2'h1;
  localparam logic [7:0] RST_STATUS          = 8'h00;
  localparam logic [31:0] BASE_SLOW_BPS      = 32'd750000;
  localparam logic [31:0] BASE_FAST_BPS      = 32'd6000000;
  localparam logic [31:0] DEFAULT_BPS        = 32'd9600;
  localparam int          CLK_HZ             = 100000000;
  localparam int          RATE_APPLY_US      = 1000;
  localparam int          RATE_APPLY_CYC     = RATE_APPLY_US * (CLK_HZ / 1000000);
  localparam int          EXEC_CYC           = 4;

  // ****************************************************
  // Carriers
  // ****************************************************
  typedef struct packed {
    logic       valid;
    logic       is_cmd;
    logic [7:0] data;
  } sfcd_in_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sfcd_out_s;

  typedef struct packed {
    logic        valid;
    logic        is_name;
    logic [7:0]  addr;
    logic [7:0]  data;
  } sfcd_wr_s;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_PARAM  = 4'h1,
    ST_LEN    = 4'h2,
    ST_STREAM = 4'h3,
    ST_EXEC   = 4'h4,
    ST_RATE   = 4'h5,
    ST_RD_LEN = 4'h6,
    ST_RD_DAT = 4'h7
  } sfcd_state_e;

endpackage

// ===== src/sfcd_decoder.sv
`timescale 1ns/1ns
module sfcd_decoder #(
  parameter logic [5:0] VERSION_NUM = 6'h05, // Arbitrary value
  parameter int         RATE_CYC    = sfcd_pkg::RATE_APPLY_CYC,
  parameter int         FIFO_DEPTH  = 2
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  input  wire sfcd_pkg::sfcd_in_s i_host,
  output logic                  o_host_ready,
  output sfcd_pkg::sfcd_out_s   o_resp,
  input  wire logic             i_resp_ready,
  input  wire logic [2:0]       i_rate_pins,
  output logic [31:0]           o_baud_bps,
  output sfcd_pkg::sfcd_wr_s    o_buf_wr,
  output logic [7:0]            o_exec_cmd,
  output logic [31:0]           o_exec_arg,
  output logic [15:0]           o_exec_count,
  output logic                  o_exec_start,
  input  wire logic             i_exec_done,
  input  wire logic             i_exec_ok,
  input  wire logic [7:0]       i_exec_status,
  input  wire logic [7:0]       i_rx_len,
  output logic [7:0]            o_rx_addr,
  input  wire logic [7:0]       i_rx_data,
  output logic                  o_int_n
);

  // ****************************************************
  // Helpers
  // ****************************************************
  // Bytes of parameters before execution, 0 = no parameter bytes
  function automatic logic [2:0] param_bytes(input logic [7:0] c);
    param_bytes = 3'd0;
    if (c == sfcd_pkg::CMD_SERIAL_RATE_SET) param_bytes = 3'd2;
    else if (c == sfcd_pkg::CMD_OFS_BUF_WRITE) param_bytes = 3'd1;
    else if (c == sfcd_pkg::CMD_FILE_CLOSE) param_bytes = 3'd1;
    else if (c == sfcd_pkg::CMD_DIR_ENTRY_READ) param_bytes = 3'd1;
    else if (c == sfcd_pkg::CMD_BYTE_SEEK) param_bytes = 3'd4;
    else if (c == sfcd_pkg::CMD_SECTOR_SEEK) param_bytes = 3'd4;
    else if (c == sfcd_pkg::CMD_BYTE_READ) param_bytes = 3'd2;
    else if (c == sfcd_pkg::CMD_BYTE_WRITE) param_bytes = 3'd2;
    else if (c == sfcd_pkg::CMD_SECTOR_READ) param_bytes = 3'd1;
    else if (c == sfcd_pkg::CMD_SECTOR_WRITE) param_bytes = 3'd1;
    else if (c == sfcd_pkg::CMD_PHYS_READ) param_bytes = 3'd5;
    else if (c == sfcd_pkg::CMD_PHYS_WRITE) param_bytes = 3'd5;
  endfunction

  function automatic logic is_exec(input logic [7:0] c);
    is_exec = (c >= sfcd_pkg::CMD_DISK_ATTACH &&
               c <= sfcd_pkg::CMD_DIR_CREATE) ||
              c == sfcd_pkg::CMD_SECTOR_SEEK ||
              c == sfcd_pkg::CMD_SECTOR_READ ||
              c == sfcd_pkg::CMD_SECTOR_WRITE ||
              c == sfcd_pkg::CMD_BULK_ONLY ||
              (c >= sfcd_pkg::CMD_PHYS_READ &&
               c <= sfcd_pkg::CMD_PHYS_WRITE_NEXT);
  endfunction

  function automatic logic [31:0] rate_of(input logic [7:0] f,
                                          input logic [7:0] k);
    logic [8:0] den;
    den = 9'h100 - {1'b0, k};
    if (den == 9'h000) rate_of = 32'h0;
    else if (f == sfcd_pkg::RATE_FACTOR_SLOW)
      rate_of = sfcd_pkg::BASE_SLOW_BPS / {23'h0, den};
    else
      rate_of = sfcd_pkg::BASE_FAST_BPS / {23'h0, den};
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    sfcd_pkg::sfcd_state_e st;
    logic [7:0]  cmd;
    logic [2:0]  pcnt;
    logic [39:0] params;
    logic [7:0]  len;
    logic [7:0]  addr;
    logic [19:0] cnt;
    logic [7:0]  int_status;
    logic        int_pend;
    logic [31:0] baud;
    logic        exec_start;
    logic [2:0]  pins_s1;
    logic [2:0]  pins_s2;
    logic [1:0]  strap_cnt;
    sfcd_pkg::sfcd_wr_s wr;
    logic        push;
    logic [7:0]  push_data;
  } sfcd_state_s;

  sfcd_state_s s_r;
  sfcd_state_s s_nxt;

  // Two-entry response buffer
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [1:0] fifo_cnt_r;
  logic       fifo_wp_r;
  logic       fifo_rp_r;
  logic       fifo_full;
  logic       fifo_pop;

  assign fifo_full = (fifo_cnt_r == 2'(FIFO_DEPTH));
  assign fifo_pop  = (fifo_cnt_r != 2'h0) && i_resp_ready;
  assign o_resp.valid = (fifo_cnt_r != 2'h0);
  assign o_resp.data  = fifo_mem[fifo_rp_r];

  // Stall host while output full or busy producing
  assign o_host_ready = !fifo_full && !s_r.push &&
                        s_r.st != sfcd_pkg::ST_EXEC &&
                        s_r.st != sfcd_pkg::ST_RATE &&
                        s_r.st != sfcd_pkg::ST_RD_DAT;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      fifo_cnt_r <= 2'h0;
      fifo_wp_r  <= 1'b0;
      fifo_rp_r  <= 1'b0;
    end
    else
    begin
      if (s_r.push)
        fifo_wp_r <= !fifo_wp_r;
      if (fifo_pop)
        fifo_rp_r <= !fifo_rp_r;
      fifo_cnt_r <= fifo_cnt_r + 2'(s_r.push) - 2'(fifo_pop);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (s_r.push)
      fifo_mem[fifo_wp_r] <= s_r.push_data;
  end

  // ****************************************************
  // Command sequencer
  // ****************************************************
  logic take;
  assign take = i_host.valid && o_host_ready;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.exec_start = 1'b0;
    s_nxt.wr.valid = 1'b0;
    s_nxt.push = 1'b0;
    s_nxt.pins_s1 = i_rate_pins;
    s_nxt.pins_s2 = s_r.pins_s1;
    // Strap read once both sync stages hold the pins
    if (s_r.strap_cnt != 2'h3)
    begin
      s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
      if (s_r.strap_cnt == 2'h2)
        s_nxt.baud = sfcd_pkg::DEFAULT_BPS >> s_r.pins_s2;
    end
    if (take && i_host.is_cmd)
    begin
      s_nxt.cmd = i_host.data;
      s_nxt.pcnt = 3'd0;
      s_nxt.params = 40'h0;
      s_nxt.addr = 8'h00;
      s_nxt.st = sfcd_pkg::ST_IDLE;
      if (i_host.data == sfcd_pkg::CMD_VERSION_QUERY)
      begin
        s_nxt.push = 1'b1;
        s_nxt.push_data = {1'b0, 1'b1, VERSION_NUM};
      end
      else if (i_host.data == sfcd_pkg::CMD_STATUS_FETCH)
      begin
        s_nxt.push = 1'b1;
        s_nxt.push_data = s_r.int_status;
        s_nxt.int_pend = 1'b0;
      end
      else if (i_host.data == sfcd_pkg::CMD_RESULT_DATA_RD)
        s_nxt.st = sfcd_pkg::ST_RD_LEN;
      else if (i_host.data == sfcd_pkg::CMD_HOST_BUF_WRITE)
        s_nxt.st = sfcd_pkg::ST_LEN;
      else if (i_host.data == sfcd_pkg::CMD_FILE_NAME_SET)
        s_nxt.st = sfcd_pkg::ST_STREAM;
      else if (param_bytes(i_host.data) != 3'd0)
        s_nxt.st = sfcd_pkg::ST_PARAM;
      else if (is_exec(i_host.data))
      begin
        s_nxt.st = sfcd_pkg::ST_EXEC;
        s_nxt.exec_start = 1'b1;
      end
    end
    else
    begin
      case (s_r.st)
        sfcd_pkg::ST_PARAM:
          if (take)
          begin
            // Low byte first into the parameter word
            s_nxt.params[8*s_r.pcnt +: 8] = i_host.data;
            s_nxt.pcnt = s_r.pcnt + 3'd1;
            if (s_r.pcnt + 3'd1 == param_bytes(s_r.cmd))
            begin
              if (s_r.cmd == sfcd_pkg::CMD_OFS_BUF_WRITE)
              begin
                s_nxt.addr = i_host.data;
                s_nxt.st = sfcd_pkg::ST_LEN;
              end
              else if (s_r.cmd == sfcd_pkg::CMD_SERIAL_RATE_SET)
              begin
                s_nxt.cnt = 20'h0;
                s_nxt.st = sfcd_pkg::ST_RATE;
              end
              else
              begin
                s_nxt.st = sfcd_pkg::ST_EXEC;
                s_nxt.exec_start = 1'b1;
              end
            end
          end
        sfcd_pkg::ST_LEN:
          if (take)
          begin
            s_nxt.len = i_host.data;
            if (i_host.data == 8'h00)
              s_nxt.st = sfcd_pkg::ST_IDLE;
            else
              s_nxt.st = sfcd_pkg::ST_STREAM;
          end
        sfcd_pkg::ST_STREAM:
          if (take)
          begin
            s_nxt.wr.valid = 1'b1;
            s_nxt.wr.is_name = (s_r.cmd == sfcd_pkg::CMD_FILE_NAME_SET);
            s_nxt.wr.addr = s_r.addr;
            s_nxt.wr.data = i_host.data;
            s_nxt.addr = s_r.addr + 8'h01;
            s_nxt.len = s_r.len - 8'h01;
            if (s_r.cmd == sfcd_pkg::CMD_FILE_NAME_SET)
            begin
              if (i_host.data == 8'h00)
                s_nxt.st = sfcd_pkg::ST_IDLE;
            end
            else if (s_r.len == 8'h01)
              s_nxt.st = sfcd_pkg::ST_IDLE;
          end
        sfcd_pkg::ST_EXEC:
          if (i_exec_done)
          begin
            s_nxt.int_status = i_exec_ok ?
              sfcd_pkg::INT_SUCCESS_CODE : i_exec_status;
            s_nxt.int_pend = 1'b1;
            s_nxt.st = sfcd_pkg::ST_IDLE;
          end
        sfcd_pkg::ST_RATE:
        begin
          s_nxt.cnt = s_r.cnt + 20'h1;
          if (s_r.cnt == 20'(RATE_CYC - 1))
          begin
            s_nxt.push = 1'b1;
            s_nxt.st = sfcd_pkg::ST_IDLE;
            if (s_r.params[7:0] == sfcd_pkg::RATE_FACTOR_SLOW ||
                s_r.params[7:0] == sfcd_pkg::RATE_FACTOR_FAST)
            begin
              s_nxt.baud = rate_of(s_r.params[7:0], s_r.params[15:8]);
              s_nxt.push_data = sfcd_pkg::IMMEDIATE_OK_CODE;
            end
            else
              s_nxt.push_data = sfcd_pkg::IMMEDIATE_FAIL_CODE;
          end
        end
        sfcd_pkg::ST_RD_LEN:
          if (!fifo_full && !s_r.push)
          begin
            s_nxt.push = 1'b1;
            s_nxt.push_data = i_rx_len;
            s_nxt.len = i_rx_len;
            s_nxt.addr = 8'h00;
            s_nxt.st = (i_rx_len == 8'h00) ? sfcd_pkg::ST_IDLE :
                                             sfcd_pkg::ST_RD_DAT;
          end
        sfcd_pkg::ST_RD_DAT:
          if (!fifo_full && !s_r.push)
          begin
            s_nxt.push = 1'b1;
            s_nxt.push_data = i_rx_data;
            s_nxt.addr = s_r.addr + 8'h01;
            s_nxt.len = s_r.len - 8'h01;
            if (s_r.len == 8'h01)
              s_nxt.st = sfcd_pkg::ST_IDLE;
          end
        default:
          s_nxt.st = sfcd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s_r <= '0;
      s_r.baud <= sfcd_pkg::DEFAULT_BPS;
      s_r.int_status <= sfcd_pkg::RST_STATUS;
    end
    else
      s_r <= s_nxt;
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign o_baud_bps   = s_r.baud;
  assign o_buf_wr     = s_r.wr;
  assign o_exec_cmd   = s_r.cmd;
  assign o_exec_arg   = s_r.params[31:0];
  assign o_exec_count = (s_r.cmd == sfcd_pkg::CMD_PHYS_READ ||
                         s_r.cmd == sfcd_pkg::CMD_PHYS_WRITE) ?
                        {8'h00, s_r.params[39:32]} : s_r.params[15:0];
  assign o_exec_start = s_r.exec_start;
  assign o_rx_addr    = s_r.addr;
  assign o_int_n      = !s_r.int_pend;

endmodule

// ===== sim/sfcd_checker_assertions.sv
`timescale 1ns/1ns
module sfcd_checker #(
  parameter logic [5:0] VERSION_NUM = 6'h05
) (
  input wire logic                i_ref_clk,
  input wire logic                i_rstn,
  input wire sfcd_pkg::sfcd_in_s  i_host,
  input wire logic                o_host_ready,
  input wire sfcd_pkg::sfcd_out_s o_resp,
  input wire logic                i_resp_ready,
  input wire logic                o_exec_start,
  input wire logic [7:0]          o_exec_cmd,
  input wire logic                i_exec_done,
  input wire logic                o_int_n
);
  // ****************************************************
  // Command take qualifiers
  // ****************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  logic take_cmd;
  logic take_stat;
  assign take_cmd  = i_host.valid && i_host.is_cmd && o_host_ready;
  assign take_stat = take_cmd && i_host.data == 8'h22;

  AST_VER_RESP: assert property (
    take_cmd && i_host.data == 8'h01 && !o_resp.valid |-> ##2
    o_resp.valid && o_resp.data == {2'b01, VERSION_NUM})
    else $error("version byte wrong or late");
  AST_STAT_RESP: assert property (
    take_stat && !o_resp.valid |-> ##2 o_resp.valid)
    else $error("status byte late");
  AST_INT_SET: assert property (
    i_exec_done |=> !o_int_n)
    else $error("interrupt not raised after completion");
  AST_INT_CAUSE: assert property (
    $fell(o_int_n) |-> $past(i_exec_done))
    else $error("interrupt without completion");
  AST_INT_HOLD: assert property (
    !o_int_n && !take_stat |=> !o_int_n)
    else $error("interrupt dropped without status read");
  AST_INT_CLEAR: assert property (
    take_stat |-> ##[1:2] o_int_n)
    else $error("interrupt not cleared by status read");
  AST_EXEC_DISK: assert property (
    take_cmd && i_host.data == 8'h30 |=> o_exec_start && o_exec_cmd == 8'h30)
    else $error("disk check not started");
  AST_START_PULSE: assert property (
    o_exec_start |=> !o_exec_start)
    else $error("start longer than one cycle");
  AST_RESP_HOLD: assert property (
    o_resp.valid && !i_resp_ready |=> o_resp.valid && $stable(o_resp.data))
    else $error("response lost during stall");
endmodule

bind sfcd_decoder sfcd_checker #(.VERSION_NUM(VERSION_NUM)) chk_u (
  .i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn),
  .i_host(i_host),
  .o_host_ready(o_host_ready),
  .o_resp(o_resp),
  .i_resp_ready(i_resp_ready),
  .o_exec_start(o_exec_start),
  .o_exec_cmd(o_exec_cmd),
  .i_exec_done(i_exec_done),
  .o_int_n(o_int_n)
);

// ===== sim/sfcd_engine_model.sv
`timescale 1ns/1ns
module sfcd_engine_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_start,
  input  wire logic       i_fail,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_len,
  input  wire logic [7:0] i_addr,
  output logic            o_done,
  output logic            o_ok,
  output logic [7:0]      o_status,
  output logic [7:0]      o_rx_len,
  output logic [7:0]      o_rx_data
);
  // ****************************************************
  // Engine with prompt or slow completion
  // ****************************************************
  logic       busy_r;
  logic [4:0] wait_r;
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      busy_r   <= 1'b0;
      wait_r   <= 5'h00;
      o_done   <= 1'b0;
      o_ok     <= 1'b0;
      o_status <= 8'h00;
    end
    else
    begin
      o_done   <= 1'b0;
      o_ok     <= ~o_ok;
      o_status <= ~o_status;
      if (i_start)
      begin
        busy_r <= 1'b1;
        wait_r <= i_slow ? 5'h0c : 5'h00;
      end
      else if (busy_r && wait_r != 5'h00)
        wait_r <= wait_r - 5'h01;
      else if (busy_r)
      begin
        busy_r   <= 1'b0;
        o_done   <= 1'b1;
        o_ok     <= !i_fail;
        o_status <= i_fail ? 8'h82 : 8'h14;
      end
    end
  end
  // Receive buffer, scrambled outside the valid length
  assign o_rx_len  = i_len;
  assign o_rx_data = (i_addr < i_len) ? (i_addr ^ 8'h5a) : ~i_addr;
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
  // ****************************************************
  // Signals and instances
  // ****************************************************
  localparam logic [5:0] VER = 6'h05; // Arbitrary value
  logic                i_ref_clk, i_rstn, i_resp_ready, o_host_ready;
  logic                o_exec_start, e_done, e_ok, fail, slow, o_int_n;
  logic [2:0]          i_rate_pins;
  logic [7:0]          o_exec_cmd, e_stat, rx_len, rx_set, rx_addr, rx_data;
  logic [15:0]         o_exec_count;
  logic [31:0]         o_exec_arg, o_baud_bps;
  sfcd_pkg::sfcd_in_s  i_host;
  sfcd_pkg::sfcd_out_s o_resp;
  sfcd_pkg::sfcd_wr_s  o_buf_wr;
  int                  n_mismatch, comparisons, cyc;
  integer              seed;
  logic [7:0]          rq[$];
  logic [16:0]         wq[$];
  logic [55:0]         xq[$];
  logic [7:0]          xc[25] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
    8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e,
    8'h3f, 8'h40, 8'h4a, 8'h4b, 8'h4c, 8'h50, 8'h54, 8'h55, 8'h56, 8'h57};

  sfcd_decoder #(.VERSION_NUM(VER), .RATE_CYC(10)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_host(i_host),
    .o_host_ready(o_host_ready), .o_resp(o_resp),
    .i_resp_ready(i_resp_ready), .i_rate_pins(i_rate_pins),
    .o_baud_bps(o_baud_bps), .o_buf_wr(o_buf_wr), .o_exec_cmd(o_exec_cmd),
    .o_exec_arg(o_exec_arg), .o_exec_count(o_exec_count),
    .o_exec_start(o_exec_start), .i_exec_done(e_done), .i_exec_ok(e_ok),
    .i_exec_status(e_stat), .i_rx_len(rx_len), .o_rx_addr(rx_addr),
    .i_rx_data(rx_data), .o_int_n(o_int_n));
  sfcd_engine_model eng_u (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_start(o_exec_start),
    .i_fail(fail), .i_slow(slow), .i_len(rx_set), .i_addr(rx_addr),
    .o_done(e_done), .o_ok(e_ok), .o_status(e_stat), .o_rx_len(rx_len),
    .o_rx_data(rx_data));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // Monitors sample mid-cycle where everything has settled
  always @(negedge i_ref_clk)
  begin
    if (o_resp.valid && i_resp_ready) rq.push_back(o_resp.data);
    if (o_buf_wr.valid)
      wq.push_back({o_buf_wr.is_name, o_buf_wr.addr, o_buf_wr.data});
    if (o_exec_start) xq.push_back({o_exec_cmd, o_exec_arg, o_exec_count});
  end
  // Receiver stalls at random
  always @(posedge i_ref_clk)
  begin
    #1;
    i_resp_ready = ($random(seed) & 3) != 0;
  end
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****************************************************
  // Tasks and expectations
  // ****************************************************
  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic send(input logic c, input logic [7:0] d, input logic last);
    logic took;
    i_host = {1'b1, c, d};
    took = 1'b0;
    while (!took)
    begin
      #8;
      took = o_host_ready;
      tick(1);
    end
    if (last) i_host.valid = 1'b0;
  endtask
  task automatic expr(input logic [7:0] e);
    int k;
    k = 0;
    while (rq.size() == 0 && k < 500)
    begin
      tick(1);
      k++;
    end
    check({24'h0, (rq.size() != 0) ? rq.pop_front() : 8'hxx}, {24'h0, e});
  endtask
  function automatic int np_of(input logic [7:0] c);
    case (c)
      8'h36, 8'h37, 8'h4b, 8'h4c: return 1;
      8'h3a, 8'h3c: return 2;
      8'h39, 8'h4a: return 4;
      8'h54, 8'h56: return 5;
      default: return 0;
    endcase
  endfunction
  function automatic logic [31:0] baud_of(input logic [7:0] f,
                                          input logic [7:0] c,
                                          input logic [31:0] old);
    if (f == 8'h02) return 32'd750000 / (32'd256 - c);
    if (f == 8'h03) return 32'd6000000 / (32'd256 - c);
    return old;
  endfunction
  task automatic do_reset(input logic [2:0] pins);
    i_rate_pins = pins;
    i_rstn = 1'b0;
    tick(4);
    i_rstn = 1'b1;
    rq.delete();
    wq.delete();
    xq.delete();
    check({31'h0, o_int_n}, 32'h1);
    tick(5);
    check(o_baud_bps, 32'd9600 >> pins);
  endtask
  task automatic run_exec(input logic [7:0] c, input logic fl);
    logic [31:0] arg;
    logic [7:0]  cnt;
    logic [55:0] x;
    int          i, np;
    arg = $random(seed);
    cnt = $random(seed);
    np = np_of(c);
    fail = fl;
    slow = $random(seed);
    send(1'b1, c, np == 0);
    for (i = 0; i < np; i++)
      send(1'b0, (i < 4) ? arg[8*i +: 8] : cnt, i == np - 1);
    i = 0;
    while (o_int_n !== 1'b0 && i < 100)
    begin
      tick(1);
      i++;
    end
    check({31'h0, o_int_n}, 32'h0);
    x = (xq.size() != 0) ? xq.pop_front() : 56'hx;
    check({24'h0, x[55:48]}, {24'h0, c});
    if (np == 1) check({24'h0, x[23:16]}, {24'h0, arg[7:0]});
    if (np == 2) check({16'h0, x[31:16]}, {16'h0, arg[15:0]});
    if (np >= 4) check(x[47:16], arg);
    if (np == 5) check({24'h0, x[7:0]}, {24'h0, cnt});
    send(1'b1, 8'h22, 1'b1);
    expr(fl ? 8'h82 : 8'h14);
    tick(3);
    check({31'h0, o_int_n}, 32'h1);
  endtask
  task automatic buf_test(input logic [7:0] c);
    logic [7:0] ofs, n, d;
    int         i, m;
    logic       nm;
    nm = (c == 8'h2f);
    ofs = (c == 8'h2e) ? ($random(seed) & 8'h7f) : 8'h00;
    n = 8'h01 + ($random(seed) & 3);
    m = nm ? n + 1 : n;
    send(1'b1, c, 1'b0);
    if (c == 8'h2e) send(1'b0, ofs, 1'b0);
    if (!nm) send(1'b0, n, 1'b0);
    for (i = 0; i < m; i++)
    begin
      d = nm ? ((i == n) ? 8'h00 : (($random(seed) & 8'h7f) | 8'h01))
             : $random(seed);
      send(1'b0, d, 1'b1);
      tick(2);
      check({15'h0, (wq.size() != 0) ? wq.pop_front() : 17'hx},
            {15'h0, nm, ofs + i[7:0], d});
    end
  endtask
  task automatic rate(input logic [7:0] f, input logic [7:0] c);
    logic [31:0] b;
    b = baud_of(f, c, o_baud_bps);
    send(1'b1, 8'h02, 1'b0);
    send(1'b0, f, 1'b0);
    send(1'b0, c, 1'b1);
    expr((f == 8'h02 || f == 8'h03) ? 8'h51 : 8'h5f);
    check(o_baud_bps, b);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial
  begin
    seed = 32'he98b23a6;
    i_host = '0;
    i_resp_ready = 1'b1;
    fail = 1'b0;
    slow = 1'b0;
    rx_set = 8'h00;
    do_reset(3'h0);
    send(1'b1, 8'h01, 1'b1);
    expr({2'b01, VER});
    buf_test(8'h2c);
    buf_test(8'h2e);
    buf_test(8'h2f);
    for (int k = 0; k < 3; k++)
    begin
      rx_set = $random(seed) & 3;
      send(1'b1, 8'h27, 1'b1);
      expr(rx_set);
      for (int j = 0; j < rx_set; j++)
        expr(j[7:0] ^ 8'h5a);
    end
    foreach (xc[k]) run_exec(xc[k], (k % 6) == 5);
    rate(8'h02, 8'hb2);
    rate(8'h03, 8'hcc);
    rate(8'h07, 8'hf3);
    do_reset(3'h2);
    rate(8'h03, 8'hfe);
    end_sim();
  end
endmodule
